// File: design/adc_irq_enable.sv
// Converter event interrupt enables with Wishbone register access
// Operation
// - Bit 0 one sets conversion start enable
// - Bit 1 one sets buffer end enable
// - Bit 2 one sets sample done enable
// - Bit 3 one sets result stored enable
// - Bit 4 one sets calibration complete enable
// - Bit 5 one sets converter converter_event_b enable
// - Bits 6-11 channels 0-2 upper, lower
// - Bits 12-17 channels 3-5 upper, lower
// - Bit 18 one sets channel 6 upper
// - Bits 19-21 channel 6 lower, channel 7
//
// The Wishbone slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none

module adc_irq_enable #(
  parameter int EVENT_COUNT = adc_irq_pkg::EVENT_COUNT
) (
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  input  wire logic                       cyc_i,
  input  wire logic                       stb_i,
  input  wire logic                       we_i,
  input  wire logic [11:0]                adr_i,
  input  wire logic [3:0]                 sel_i,
  input  wire logic [31:0]                dat_i,
  output var  logic [31:0]                dat_o,
  output var  logic                       ack_o,
  input  wire logic [EVENT_COUNT-1:0]     event_i,
  output var  logic [EVENT_COUNT-1:0]     enables_o,
  output var  logic                       irq_o
);

  ////////////////////////////////////////////////////////////////////////
  // Bus decode

  logic                   ack_reg;
  logic [31:0]            dat_reg;
  logic [EVENT_COUNT-1:0] enable_reg;
  logic [EVENT_COUNT-1:0] enable_next;
  logic [EVENT_COUNT-1:0] mask_reg;
  logic [EVENT_COUNT-1:0] mask_next;
  logic                   irq_reg;
  logic [EVENT_COUNT-1:0] status_flags;

  wire        request     = cyc_i & stb_i;
  wire        commit      = request & ack_reg;
  wire        wr_commit   = commit & we_i;
  wire        rd_commit   = commit & ~we_i;
  wire [11:0] word_adr    = {adr_i[11:2], 2'b00};

  wire hit_status  = word_adr == adc_irq_pkg::STATUS_OFFSET;
  wire hit_mask    = word_adr == adc_irq_pkg::MASK_OFFSET;
  wire hit_set     = word_adr == adc_irq_pkg::ENABLE_SET_OFFSET;
  wire hit_clr     = word_adr == adc_irq_pkg::ENABLE_CLR_OFFSET;

  // Byte lanes not selected carry zeros, so they never set or clear an enable, but a mask write loads them as zero
  wire [31:0] lane_mask = {{8{sel_i[3]}}, {8{sel_i[2]}},
                           {8{sel_i[1]}}, {8{sel_i[0]}}};
  wire [31:0] wr_data   = dat_i & lane_mask;

  // Upper bits beyond the event field are dropped on write
  wire [EVENT_COUNT-1:0] wr_bits = wr_data[EVENT_COUNT-1:0];

  wire set_write  = wr_commit & hit_set;
  wire clr_write  = wr_commit & hit_clr;
  wire mask_write = wr_commit & hit_mask;
  wire stat_read  = rd_commit & hit_status;

  ////////////////////////////////////////////////////////////////////////
  // Enable register

  // Bit b of the word is event b
  // Only ones act; zeros leave the enable alone
  wire [EVENT_COUNT-1:0] set_bits = set_write ? wr_bits : '0;
  wire [EVENT_COUNT-1:0] clr_bits = clr_write ? wr_bits : '0;

  // Set and clear registers are separate words, so they never collide
  assign enable_next = set_bits | (enable_reg & ~clr_bits);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      enable_reg <= adc_irq_pkg::ENABLE_RESET[EVENT_COUNT-1:0];
    end
    else
    begin
      enable_reg <= enable_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Status and mask

  // Only enabled events are latched; a read of status clears them
  wire [EVENT_COUNT-1:0] status_set = event_i & enable_reg;
  // Only the bits already in the read word are cleared, so an event
  // landing between the ack edge and the commit edge is not lost
  wire [EVENT_COUNT-1:0] status_clr =
      stat_read ? dat_reg[EVENT_COUNT-1:0] : '0;

  sticky_flags #(
    .WIDTH (EVENT_COUNT),
    .RESET (adc_irq_pkg::STATUS_RESET)
  ) status_flags_inst (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .set_i   (status_set),
    .clear_i (status_clr),
    .flags_o (status_flags)
  );

  assign mask_next = mask_write ? wr_bits : mask_reg;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mask_reg <= adc_irq_pkg::MASK_RESET[EVENT_COUNT-1:0];
    end
    else
    begin
      mask_reg <= mask_next;
    end
  end

  // Built from the next flags and the next mask, so the flop tracks
  // status and mask without a cycle of lag
  wire [EVENT_COUNT-1:0] status_next = status_set |
                                       (status_flags & ~status_clr);
  wire irq_next = |(status_next & mask_next);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      irq_reg <= 1'b0;
    end
    else
    begin
      irq_reg <= irq_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read path and acknowledge

  // Both enable words read the live enables
  wire [EVENT_COUNT-1:0] rd_field =
      (hit_set | hit_clr) ? enable_reg   :
      hit_mask            ? mask_reg     :
      hit_status          ? status_flags : '0;

  // Unmapped reads answer zero; bits above the field stay zero
  wire [31:0] rd_word = {{(32 - EVENT_COUNT){1'b0}}, rd_field};

  // Ack one cycle after the request, dropped the cycle after
  wire ack_next = request & ~ack_reg;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h00000000;
    end
    else
    begin
      ack_reg <= ack_next;
      dat_reg <= ack_next ? rd_word : dat_reg;
    end
  end

  assign ack_o     = ack_reg;
  assign dat_o     = dat_reg;
  assign enables_o = enable_reg;
  assign irq_o     = irq_reg;

  ////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_set_one(int b);
    set_write && wr_bits[b];
  endsequence

  sequence s_clr_one(int b);
    clr_write && wr_bits[b];
  endsequence

  // First cycle of an access, before the slave has answered
  sequence s_new_request;
    request && !ack_reg;
  endsequence

  property p_set_bit(int b);
    s_set_one(b) |=> enable_reg[b];
  endproperty

  property p_clr_bit(int b);
    s_clr_one(b) |=> !enable_reg[b];
  endproperty

  property p_hold_bit(int b);
    enable_reg[b] && !(clr_write && wr_bits[b]) |=> enable_reg[b];
  endproperty

  a_set_conv_start: assert property (
    p_set_bit(adc_irq_pkg::CONV_EVENT_A_BIT))
    else $error("conversion start enable not set");

  a_hold_conv_start: assert property (
    p_hold_bit(adc_irq_pkg::CONV_EVENT_A_BIT))
    else $error("conversion start enable dropped");

  a_set_buffer_end: assert property (
    p_set_bit(adc_irq_pkg::BUFFER_END_BIT))
    else $error("buffer end enable not set");

  a_set_sample_done: assert property (
    p_set_bit(adc_irq_pkg::SAMPLE_DONE_BIT))
    else $error("sample done enable not set");

  a_set_result_stored: assert property (
    p_set_bit(adc_irq_pkg::RESULT_STORED_BIT))
    else $error("result stored enable not set");

  a_set_calibration: assert property (
    p_set_bit(adc_irq_pkg::CALIBRATION_BIT))
    else $error("calibration enable not set");

  a_set_conv_stop: assert property (
    p_set_bit(adc_irq_pkg::CONVERTER_EVENT_B_BIT))
    else $error("converter converter_event_b enable not set");

  for (genvar c = 0; c < 3; c++)
  begin : g_low_chan
    localparam int UB = adc_irq_pkg::LIMIT_BASE_BIT
                      + c * adc_irq_pkg::LIMIT_BITS_PER_CHAN;
    a_set_low_upper: assert property (p_set_bit(UB))
      else $error("low channel upper enable not set");
    a_set_low_lower: assert property (
      p_set_bit(UB + adc_irq_pkg::LIMIT_LOWER_STEP))
      else $error("low channel lower enable not set");
  end

  for (genvar c = 3; c < 6; c++)
  begin : g_mid_chan
    localparam int UB = adc_irq_pkg::LIMIT_BASE_BIT
                      + c * adc_irq_pkg::LIMIT_BITS_PER_CHAN;
    a_set_mid_upper: assert property (p_set_bit(UB))
      else $error("mid channel upper enable not set");
    a_set_mid_lower: assert property (
      p_set_bit(UB + adc_irq_pkg::LIMIT_LOWER_STEP))
      else $error("mid channel lower enable not set");
  end

  a_set_chan6_upper: assert property (p_set_bit(18))
    else $error("channel 6 upper enable not set");

  a_set_chan6_lower: assert property (p_set_bit(19))
    else $error("channel 6 lower enable not set");

  a_set_chan7_both: assert property (
    set_write && wr_bits[21:20] == 2'b11 |=> enable_reg[21:20] == 2'b11)
    else $error("channel 7 enables not set");

  // Every enable holds until the clear word names it
  for (genvar i = 0; i < EVENT_COUNT; i++)
  begin : g_each_bit
    a_hold_each: assert property (p_hold_bit(i))
      else $error("enable dropped without a clear");
    a_clear_each: assert property (p_clr_bit(i))
      else $error("enable not cleared by clear write");
  end

  a_zero_keeps: assert property (
    set_write |=> enable_reg == ($past(enable_reg) | $past(wr_bits)))
    else $error("set write disturbed other enables");

  a_read_enables: assert property (
    request && !ack_reg && !we_i && hit_set
    |=> ack_reg && dat_o == {10'h000, $past(enable_reg)})
    else $error("enable read returned wrong value");

  a_reset_clears: assert property (
    disable iff (1'b0) rst_i |=> enable_reg == '0 && !ack_o && !irq_o)
    else $error("reset did not clear enables");

  a_upper_zero: assert property (
    ack_o |-> dat_o[31:EVENT_COUNT] == '0)
    else $error("upper bits read non-zero");

  a_unmapped_zero: assert property (
    s_new_request ##0 !(hit_status || hit_mask || hit_set || hit_clr)
    |=> dat_o == '0)
    else $error("unmapped read returned non-zero");

  a_read_mask: assert property (
    s_new_request ##0 (!we_i && hit_mask)
    |=> dat_o == {10'h000, $past(mask_reg)})
    else $error("mask read returned wrong value");

  a_mask_write: assert property (
    mask_write |=> mask_reg == $past(wr_bits))
    else $error("mask write did not land");

  a_ack_follows: assert property (
    s_new_request |=> ack_o)
    else $error("request not acknowledged after one cycle");

  a_no_stray_ack: assert property (
    !request |=> !ack_o)
    else $error("acknowledge without a request");

  a_ack_single: assert property (
    ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");

  a_status_set: assert property (
    event_i[0] && enable_reg[0] |=> status_flags[0])
    else $error("enabled event not latched");

  a_disabled_drop: assert property (
    !enable_reg[0] && !status_flags[0] |=> !status_flags[0])
    else $error("disabled event reached status");

  a_status_keeps: assert property (
    !stat_read
    |=> (status_flags & $past(status_flags)) == $past(status_flags))
    else $error("status bit lost without a read");

  a_read_clear: assert property (
    stat_read && dat_reg[0] && !(event_i[0] && enable_reg[0])
    |=> !status_flags[0])
    else $error("reported status bit not cleared");

  a_irq_follows: assert property (
    irq_o == |(status_flags & mask_reg))
    else $error("interrupt line disagrees with unmasked status");

endmodule : adc_irq_enable

`default_nettype wire

// File: design/adc_irq_pkg.sv
// Constants shared by the converter interrupt enable block
package adc_irq_pkg;

  localparam int ADDR_WIDTH  = 12;
  localparam int DATA_WIDTH  = 32;
  localparam int EVENT_COUNT = 22;
  localparam int CHAN_COUNT  = 8;

  // Word offsets of the register window
  localparam logic [11:0] STATUS_OFFSET     = 12'h100;
  localparam logic [11:0] MASK_OFFSET       = 12'h104;
  localparam logic [11:0] ENABLE_SET_OFFSET = 12'h304;
  localparam logic [11:0] ENABLE_CLR_OFFSET = 12'h308;

  // Bit positions of the events
  localparam int CONV_EVENT_A_BIT        = 0;
  localparam int BUFFER_END_BIT          = 1;
  localparam int SAMPLE_DONE_BIT         = 2;
  localparam int RESULT_STORED_BIT       = 3;
  localparam int CALIBRATION_BIT         = 4;
  localparam int CONVERTER_EVENT_B_BIT   = 5;
  localparam int LIMIT_BASE_BIT          = 6;
  localparam int LIMIT_BITS_PER_CHAN     = 2;
  localparam int LIMIT_LOWER_STEP        = 1;

  // Reset values
  localparam logic [21:0] ENABLE_RESET = 22'h000000;
  localparam logic [21:0] STATUS_RESET = 22'h000000;
  localparam logic [21:0] MASK_RESET   = 22'h000000;

endpackage : adc_irq_pkg

// File: design/sticky_flags.sv
// Row of sticky flags where a set beats a simultaneous clear
`timescale 1ns/1ps
`default_nettype none

module sticky_flags #(
  parameter int          WIDTH = 22,
  parameter logic [21:0] RESET = 22'h000000
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] set_i,
  input  wire logic [WIDTH-1:0] clear_i,
  output var  logic [WIDTH-1:0] flags_o
);

  logic [WIDTH-1:0] flags_reg;
  logic [WIDTH-1:0] flags_next;

  // An event landing in the clearing cycle is kept
  assign flags_next = set_i | (flags_reg & ~clear_i);
  assign flags_o    = flags_reg;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      flags_reg <= RESET[WIDTH-1:0];
    end
    else
    begin
      flags_reg <= flags_next;
    end
  end

endmodule : sticky_flags

`default_nettype wire

// File: sim/adc_irq_enable_test.sv
// Self-checking bench for the converter interrupt enable block
`timescale 1ns/1ps
`default_nettype none

module adc_irq_enable_test;
  localparam logic [11:0] SET_ADR = adc_irq_pkg::ENABLE_SET_OFFSET;
  localparam logic [11:0] CLR_ADR = adc_irq_pkg::ENABLE_CLR_OFFSET;
  localparam logic [11:0] STA_ADR = adc_irq_pkg::STATUS_OFFSET;
  localparam logic [11:0] MSK_ADR = adc_irq_pkg::MASK_OFFSET;

  logic        clk_i;
  logic        rst_i;
  logic        cyc_i;
  logic        stb_i;
  logic        we_i;
  logic [11:0] adr_i;
  logic [3:0]  sel_i;
  logic [31:0] dat_i;
  logic [31:0] dat_o;
  logic        ack_o;
  logic [21:0] event_i;
  logic [21:0] enables_o;
  logic        irq_o;
  logic [31:0] en_word;
  logic [31:0] rd;
  int          bad_count;
  int          cmp_count;

  assign en_word = {10'h000, enables_o};

  adc_irq_enable dut (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .cyc_i     (cyc_i),
    .stb_i     (stb_i),
    .we_i      (we_i),
    .adr_i     (adr_i),
    .sel_i     (sel_i),
    .dat_i     (dat_i),
    .dat_o     (dat_o),
    .ack_o     (ack_o),
    .event_i   (event_i),
    .enables_o (enables_o),
    .irq_o     (irq_o)
  );

  always #5 clk_i = ~clk_i;

  ////////////////////////////////////////////////////////////////////////////
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : complete_run

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_word

  task automatic check_bit(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_bit

  // Holds the request until ack is sampled; one idle cycle follows
  task automatic bus(input logic we, input logic [11:0] adr,
                     input logic [3:0] sel, input logic [31:0] wdat);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= we;
    adr_i <= adr;
    sel_i <= sel;
    dat_i <= wdat;
    do
    begin
      @(posedge clk_i);
    end
    while (ack_o !== 1'b1);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
    @(posedge clk_i);
  endtask : bus

  task automatic pulse(input logic [21:0] e);
    event_i <= e;
    @(posedge clk_i);
    event_i <= 22'h000000;
    @(posedge clk_i);
  endtask : pulse

  ////////////////////////////////////////////////////////////////////////////
  task automatic test_reset;
    check_word(en_word, 32'h00000000);
    check_bit(irq_o, 1'b0);
    bus(1'b0, SET_ADR, 4'hf, 32'h00000000);
    check_word(rd, 32'h00000000);
  endtask : test_reset

  // Walking one: each bit adds exactly its own enable to the earlier ones
  task automatic walk_set(input int lo, input int hi);
    for (int b = lo; b <= hi; b++)
    begin
      bus(1'b1, SET_ADR, 4'hf, 32'h00000001 << b);
      check_word(en_word, (32'h00000002 << b) - 32'h00000001);
    end
  endtask : walk_set

  task automatic test_each_bit;
    walk_set(0, 2);
    walk_set(3, 5);
    walk_set(6, 17);
    walk_set(18, 21);
    bus(1'b0, SET_ADR, 4'hf, 32'h00000000);
    check_word(rd, 32'h003fffff);
    bus(1'b1, CLR_ADR, 4'hf, 32'hffffffff);
    check_word(en_word, 32'h00000000);
  endtask : test_each_bit

  task automatic test_zero_upper;
    bus(1'b1, SET_ADR, 4'hf, 32'h00000005);
    bus(1'b1, SET_ADR, 4'hf, 32'h00000000);
    check_word(en_word, 32'h00000005);
    bus(1'b1, SET_ADR, 4'hf, 32'hffc00000);
    bus(1'b0, SET_ADR, 4'hf, 32'h00000000);
    check_word(rd, 32'h00000005);
    bus(1'b1, SET_ADR, 4'h2, 32'hffffffff);
    check_word(en_word, 32'h0000ff05);
    bus(1'b1, 12'h200, 4'hf, 32'hffffffff);
    bus(1'b0, 12'h200, 4'hf, 32'h00000000);
    check_word(rd, 32'h00000000);
    bus(1'b1, CLR_ADR, 4'hf, 32'hffffffff);
  endtask : test_zero_upper

  // Enabled events latch in status; only masked-in ones reach the line
  task automatic test_irq;
    bus(1'b1, MSK_ADR, 4'hf, 32'h00000001);
    bus(1'b0, MSK_ADR, 4'hf, 32'h00000000);
    check_word(rd, 32'h00000001);
    bus(1'b1, SET_ADR, 4'hf, 32'h00000003);
    pulse(22'h000003);
    check_bit(irq_o, 1'b1);
    bus(1'b0, STA_ADR, 4'hf, 32'h00000000);
    check_word(rd, 32'h00000003);
    check_bit(irq_o, 1'b0);
    pulse(22'h000006);
    check_bit(irq_o, 1'b0);
    bus(1'b0, STA_ADR, 4'hf, 32'h00000000);
    check_word(rd, 32'h00000002);
  endtask : test_irq

  // A reset in mid-run drops every enable the earlier writes left
  task automatic test_reset_again;
    bus(1'b1, SET_ADR, 4'hf, 32'h003fffff);
    check_word(en_word, 32'h003fffff);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    check_word(en_word, 32'h00000000);
    check_bit(irq_o, 1'b0);
  endtask : test_reset_again

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk_i = 1'b0;
    rst_i = 1'b1;
    cyc_i = 1'b0;
    stb_i = 1'b0;
    we_i = 1'b0;
    adr_i = 12'h000;
    sel_i = 4'h0;
    dat_i = 32'h00000000;
    event_i = 22'h000000;
    bad_count = 0;
    cmp_count = 0;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    test_reset();
    test_each_bit();
    test_zero_upper();
    test_irq();
    test_reset_again();
    complete_run();
  end

  // The tests need about 130 cycles; a hang is cut off well past that
  initial
  begin
    repeat (5000) @(posedge clk_i);
    bad_count++;
    complete_run();
  end
endmodule : adc_irq_enable_test

`default_nettype wire
